// ### src/tdmps_serial_port.sv
// tdm pcm serial port: two receive and two transmit 32-channel streams
// Functional notes
// - drive both outputs only when enable pin and control bit are high
// - either enable low puts both output pins in high impedance
// - send-out stream shifted out at 2.048 Mbps, 32 timeslots per frame
// - receive-out stream shifted out at 2.048 Mbps, 32 timeslots per frame
// - send-in stream of 32 channels sampled in every channel
// - receive-in stream of 32 channels sampled in every channel
// - frame pulse polarity detected automatically, framing aligned to it
// - 4.096 MHz serial clock shifts all four streams
// - core clock may be unrelated to the frame; all pins synchronised
// - reset returns control state and output enable to defaults
`timescale 1ns/1ps
module tdmps_serial_port (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic serial_bit_clock_i,
  input wire logic frame_pulse_in_i,
  input wire logic rin_i,
  input wire logic sin_i,
  input wire logic output_drive_enable_i,
  input wire logic ctrl_ode_i,
  input wire logic tx_wr_i,
  input wire logic [tdmps_pkg::TDMPS_CHAN_W-1:0] tx_chan_i,
  input wire logic [7:0] tx_sout_byte_i,
  input wire logic [7:0] tx_rout_byte_i,
  output logic sout_o,
  output logic sout_oe_o,
  output logic rout_o,
  output logic rout_oe_o,
  output logic rx_valid_o,
  output logic [tdmps_pkg::TDMPS_CHAN_W-1:0] rx_chan_o,
  output logic [7:0] rin_byte_o,
  output logic [7:0] sin_byte_o,
  output logic frame_gci_o,
  output logic frame_locked_o
);
  import tdmps_pkg::*;

  logic [2:0] sclk_sy_r;
  logic [1:0] fp_sy_r;
  logic [1:0] rin_sy_r;
  logic [1:0] sin_sy_r;
  logic [1:0] ode_sy_r;
  logic sclk_rise;
  logic fp_prev_r;
  logic [2:0] run_r;
  logic idle_lvl_r;
  logic idle_ok_r;
  logic fp_act;
  logic [TDMPS_CNT_W-1:0] cnt_r;
  logic [TDMPS_CHAN_W-1:0] rd_chan;
  logic [15:0] rd_data;
  logic [7:0] sout_sh_r;
  logic [7:0] rout_sh_r;
  logic [7:0] rin_sh_r;
  logic [7:0] sin_sh_r;

  // pins come from the serial clock domain; first stage feeds only second
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      sclk_sy_r <= 3'h0;
      fp_sy_r <= 2'h0;
      rin_sy_r <= 2'h0;
      sin_sy_r <= 2'h0;
      ode_sy_r <= 2'h0;
    end
    else
    begin
      sclk_sy_r <= {sclk_sy_r[1:0], serial_bit_clock_i};
      fp_sy_r <= {fp_sy_r[0], frame_pulse_in_i};
      rin_sy_r <= {rin_sy_r[0], rin_i};
      sin_sy_r <= {sin_sy_r[0], sin_i};
      ode_sy_r <= {ode_sy_r[0], output_drive_enable_i};
    end
  end

  assign sclk_rise = sclk_sy_r[1] & ~sclk_sy_r[2];

  // idle level is the one held for a long run; the pulse is the other one
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      fp_prev_r <= 1'b0;
      run_r <= 3'h0;
      idle_lvl_r <= 1'b1;
      idle_ok_r <= 1'b0;
    end
    else if (sclk_rise)
    begin
      fp_prev_r <= fp_sy_r[1];
      if (fp_sy_r[1] != fp_prev_r)
      begin
        run_r <= 3'h0;
      end
      else if (run_r != TDMPS_IDLE_RUN)
      begin
        run_r <= run_r + 3'h1;
      end
      else
      begin
        idle_lvl_r <= fp_sy_r[1];
        idle_ok_r <= 1'b1;
      end
    end
  end

  assign fp_act = sclk_rise && idle_ok_r && (fp_sy_r[1] != idle_lvl_r);

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      frame_gci_o <= 1'b0;
      frame_locked_o <= 1'b0;
    end
    else
    begin
      frame_gci_o <= idle_ok_r & ~idle_lvl_r;
      if (fp_act)
      begin
        frame_locked_o <= 1'b1;
      end
    end
  end

  // half-bit counter wraps every 512 serial clocks even without pulses
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      cnt_r <= '0;
    end
    else if (fp_act)
    begin
      cnt_r <= '0;
    end
    else if (sclk_rise)
    begin
      cnt_r <= cnt_r + 9'h001;
    end
  end

  // fetch next slot's bytes for the whole current slot so registered data is ready
  assign rd_chan = cnt_r[8:4] + 5'h01;

  tdmps_chan_mem #(
    .DEPTH(TDMPS_CHANNELS),
    .AW(TDMPS_CHAN_W),
    .DW(16)
  ) u_mem (
    .clk_i(clk_i),
    .wr_en_i(tx_wr_i),
    .wr_addr_i(tx_chan_i),
    .wr_data_i({tx_sout_byte_i, tx_rout_byte_i}),
    .rd_addr_i(fp_act ? 5'h00 : rd_chan),
    .rd_data_o(rd_data)
  );

  // transmit: new bit on the rise that ends each odd half, msb first
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      sout_sh_r <= 8'h00;
      rout_sh_r <= 8'h00;
      sout_o <= 1'b1;
      rout_o <= 1'b1;
    end
    else if (sclk_rise && (fp_act || cnt_r[0]))
    begin
      // the pulse edge is also the last half of the old frame
      if (fp_act || cnt_r[3:0] == TDMPS_LAST_HALF)
      begin
        sout_o <= rd_data[15];
        rout_o <= rd_data[7];
        sout_sh_r <= {rd_data[14:8], 1'b0};
        rout_sh_r <= {rd_data[6:0], 1'b0};
      end
      else
      begin
        sout_o <= sout_sh_r[7];
        rout_o <= rout_sh_r[7];
        sout_sh_r <= {sout_sh_r[6:0], 1'b0};
        rout_sh_r <= {rout_sh_r[6:0], 1'b0};
      end
    end
  end

  // enables gate in both sources; the pad floats when either is low
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      sout_oe_o <= TDMPS_OE_RESET;
      rout_oe_o <= TDMPS_OE_RESET;
    end
    else
    begin
      sout_oe_o <= ode_sy_r[1] & ctrl_ode_i;
      rout_oe_o <= ode_sy_r[1] & ctrl_ode_i;
    end
  end

  // receive: sample mid bit, well away from the far end's data edges
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      rin_sh_r <= 8'h00;
      sin_sh_r <= 8'h00;
      rx_valid_o <= 1'b0;
      rx_chan_o <= '0;
      rin_byte_o <= 8'h00;
      sin_byte_o <= 8'h00;
    end
    else
    begin
      rx_valid_o <= 1'b0;
      if (sclk_rise && !fp_act && !cnt_r[0])
      begin
        rin_sh_r <= {rin_sh_r[6:0], rin_sy_r[1]};
        sin_sh_r <= {sin_sh_r[6:0], sin_sy_r[1]};
        if (cnt_r[3:0] == TDMPS_RX_LAST_HALF)
        begin
          rx_valid_o <= 1'b1;
          rx_chan_o <= cnt_r[8:4];
          rin_byte_o <= {rin_sh_r[6:0], rin_sy_r[1]};
          sin_byte_o <= {sin_sh_r[6:0], sin_sy_r[1]};
        end
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  oe_needs_both_a: assert property (
    sout_oe_o |-> $past(ctrl_ode_i) && $past(ode_sy_r[1]))
    else $error("output enabled without both enables");
  oe_off_a: assert property (!ctrl_ode_i |=> !sout_oe_o && !rout_oe_o)
    else $error("output driven while control enable low");
  sout_hold_a: assert property (
    sclk_rise && !fp_act && !cnt_r[0] |=> $stable(sout_o))
    else $error("send-out changed mid bit");
  pulse_load_a: assert property (
    fp_act |=> sout_o == $past(rd_data[15]) && rout_o == $past(rd_data[7]))
    else $error("frame pulse edge did not launch slot 0");
  rout_hold_a: assert property (
    sclk_rise && !fp_act && !cnt_r[0] |=> $stable(rout_o))
    else $error("receive-out changed mid bit");
  sin_slot_a: assert property (
    rx_valid_o |-> $past(cnt_r[3:0]) == TDMPS_RX_LAST_HALF)
    else $error("send-in byte taken at wrong half");
  rin_chan_a: assert property (
    rx_valid_o |-> rx_chan_o == $past(cnt_r[8:4]))
    else $error("receive-in channel mismatch");
  frame_align_a: assert property (
    fp_act |=> cnt_r == 9'h000 ##1 (!sclk_rise)[*2])
    else $error("frame pulse did not realign");
  count_by_clock_a: assert property (
    $changed(cnt_r) |-> $past(sclk_rise))
    else $error("counter moved without serial clock edge");
  // reset itself is the trigger here, so the default disable must not apply
  reset_quiet_a: assert property (
    @(posedge clk_i) disable iff (1'b0)
    !rst_n_i |=> !sout_oe_o && !rx_valid_o)
    else $error("reset did not clear outputs");
  frame_wrap_a: assert property (
    sclk_rise && !fp_act && cnt_r == 9'h1FF |=> cnt_r == 9'h000)
    else $error("frame not 512 half bits");

  rx_seen_c: cover property (rx_valid_o && rx_chan_o == 5'h1F);
  gci_seen_c: cover property (frame_gci_o && frame_locked_o);
  drive_on_c: cover property (sout_oe_o && rout_oe_o);
endmodule

// ### src/tdmps_pkg.sv
// shared constants of the tdm pcm serial port
package tdmps_pkg;
  localparam int unsigned TDMPS_CHANNELS = 32;
  localparam int unsigned TDMPS_CHAN_W = 5;
  localparam int unsigned TDMPS_BITS_PER_CHAN = 8;
  localparam int unsigned TDMPS_HALVES_PER_BIT = 2;
  // half-bit counter: channel in [8:4], bit in [3:1], half in [0]
  localparam int unsigned TDMPS_CNT_W = 9;
  localparam logic [3:0] TDMPS_LAST_HALF = 4'hF;
  localparam logic [3:0] TDMPS_PREFETCH_HALF = 4'hE;
  localparam logic [3:0] TDMPS_FIRST_HALF = 4'h0;
  // last receive sample of a slot: the middle of bit 0
  localparam logic [3:0] TDMPS_RX_LAST_HALF = 4'hE;
  // equal frame pulse repeats counted before the next equal sample sets the idle level
  localparam logic [2:0] TDMPS_IDLE_RUN = 3'h7;
  localparam logic TDMPS_OE_RESET = 1'b0;
endpackage

// ### src/tdmps_chan_mem.sv
// per-channel transmit byte store, registered read
`timescale 1ns/1ps
module tdmps_chan_mem #(
  parameter int unsigned DEPTH = 32,
  parameter int unsigned AW = 5,
  parameter int unsigned DW = 16
) (
  input wire logic clk_i,
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [DW-1:0] wr_data_i,
  input wire logic [AW-1:0] rd_addr_i,
  output logic [DW-1:0] rd_data_o
);
  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge clk_i)
  begin
    if (wr_en_i)
    begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    rd_data_o <= mem[rd_addr_i];
  end
endmodule

// ### verif/tdmps_far_end.sv
// far-end framer model: serial clock, frame pulse, rx streams, tx capture
`timescale 1ns/1ps
module tdmps_far_end (
  input wire logic gci_i,
  input wire logic [7:0] rin_tab_i [32],
  input wire logic [7:0] sin_tab_i [32],
  input wire logic sout_i,
  input wire logic rout_i,
  output logic sclk_o,
  output logic fp_o,
  output logic rin_o,
  output logic sin_o,
  output logic [7:0] cap_s_o [32],
  output logic [7:0] cap_r_o [32]
);
  logic [8:0] r_q;
  logic [8:0] nx;
  // odd offset keeps serial edges off the core clock edges
  initial
  begin
    sclk_o = 1'b0;
    fp_o = 1'b1;
    rin_o = 1'b1;
    sin_o = 1'b1;
    r_q = 9'h1FF;
    #13;
    forever #100 sclk_o = ~sclk_o;
  end
  // pulse spans exactly one rise; data moves half a period before a bit
  always @(negedge sclk_o)
  begin
    nx = r_q + 9'h001;
    fp_o = gci_i ^ (nx != 9'h000);
    if (!nx[0])
    begin
      rin_o = rin_tab_i[nx[8:4]][~nx[3:1]];
      sin_o = sin_tab_i[nx[8:4]][~nx[3:1]];
    end
  end
  // capture at the rise in the middle of each bit
  always @(posedge sclk_o)
  begin
    r_q = r_q + 9'h001;
    if (r_q[0])
    begin
      cap_s_o[r_q[8:4]][~r_q[3:1]] = sout_i;
      cap_r_o[r_q[8:4]][~r_q[3:1]] = rout_i;
    end
  end
endmodule

// ### verif/tb_tdmps_serial_port.sv
// self-checking bench of the tdm pcm serial port
`timescale 1ns/1ps
module tb_tdmps_serial_port;
  import tdmps_pkg::*;
  localparam int FRAME = 4096; // 512 serial clocks of 8 core clocks
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic gci = 1'b0, chk_on = 1'b0, output_drive_enable_i = 1'b0;
  logic ctrl_ode_i = 1'b0, tx_wr_i = 1'b0;
  logic [4:0] tx_chan_i = 5'h00;
  logic [7:0] tx_sout_byte_i = 8'h00, tx_rout_byte_i = 8'h00;
  logic sclk, fp, rin, sin, sout_o, sout_oe_o, rout_o, rout_oe_o, rx_valid_o;
  logic frame_gci_o, frame_locked_o;
  logic [4:0] rx_chan_o;
  logic [7:0] rin_byte_o, sin_byte_o;
  logic [7:0] rin_tab [32], sin_tab [32], ts [32], tr [32], cs [32], cr [32];
  logic [31:0] seen, seed = 32'd27;
  wire sout_w = sout_oe_o ? sout_o : 1'bz;
  wire rout_w = rout_oe_o ? rout_o : 1'bz;
  int fails = 0, checks_done = 0;
  always #12.5 clk_i = ~clk_i;
  tdmps_serial_port i_tdmps_serial_port (.clk_i, .rst_n_i,
    .serial_bit_clock_i(sclk), .frame_pulse_in_i(fp), .rin_i(rin),
    .sin_i(sin), .output_drive_enable_i, .ctrl_ode_i, .tx_wr_i, .tx_chan_i,
    .tx_sout_byte_i, .tx_rout_byte_i, .sout_o, .sout_oe_o, .rout_o,
    .rout_oe_o, .rx_valid_o, .rx_chan_o, .rin_byte_o, .sin_byte_o,
    .frame_gci_o, .frame_locked_o);
  tdmps_far_end i_tdmps_far_end (.gci_i(gci), .rin_tab_i(rin_tab),
    .sin_tab_i(sin_tab), .sout_i(sout_w), .rout_i(rout_w), .sclk_o(sclk),
    .fp_o(fp), .rin_o(rin), .sin_o(sin), .cap_s_o(cs), .cap_r_o(cr));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    if (fails == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk_i)
    if (chk_on && rx_valid_o)
    begin
      seen[rx_chan_o] = 1'b1;
      chk(rin_byte_o, rin_tab[rx_chan_o]);
      chk(sin_byte_o, sin_tab[rx_chan_o]);
    end
  task automatic run_mode(input logic g);
    int i;
    int k;
    gci = g;
    rst_n_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    chk(sout_oe_o, 1'b0);
    chk(frame_locked_o, 1'b0);
    rst_n_i <= 1'b1;
    // all-zero and all-one receive bytes, single-bit transmit bytes at the frame ends, random elsewhere
    for (i = 0; i < 32; i++)
    begin
      rin_tab[i] = (i == 0) ? 8'h00 : 8'(xs());
      sin_tab[i] = (i == 31) ? 8'hFF : 8'(xs());
      ts[i] = (i == 0) ? 8'h80 : 8'(xs());
      tr[i] = (i == 31) ? 8'h01 : 8'(xs());
      @(posedge clk_i);
      tx_wr_i <= 1'b1;
      tx_chan_i <= 5'(i);
      tx_sout_byte_i <= ts[i];
      tx_rout_byte_i <= tr[i];
    end
    @(posedge clk_i);
    tx_wr_i <= 1'b0;
    for (k = 0; k < 4; k++)
    begin
      output_drive_enable_i <= k[0];
      ctrl_ode_i <= k[1];
      repeat (6) @(posedge clk_i);
      chk(sout_oe_o, k[0] & k[1]);
      chk(rout_oe_o, k[0] & k[1]);
    end
    repeat (2 * FRAME) @(posedge clk_i);
    seen = '0;
    chk_on = 1'b1;
    repeat (FRAME + 8) @(posedge clk_i);
    chk_on = 1'b0;
    chk(seen, 32'hFFFFFFFF);
    chk(frame_locked_o, 1'b1);
    chk(frame_gci_o, g);
    for (i = 0; i < 32; i++)
    begin
      chk(cs[i], ts[i]);
      chk(cr[i], tr[i]);
    end
    output_drive_enable_i <= 1'b0;
    repeat (FRAME) @(posedge clk_i);
    chk(cs[7], 8'hZZ);
    chk(cr[20], 8'hZZ);
  endtask
  initial
  begin
    #2000000;
    fails++;
    close_out();
  end
  initial
  begin
    run_mode(1'b0);
    run_mode(1'b1);
    close_out();
  end
endmodule
